// ==== verilog/clock_output_enable_and_los_pkg.sv ====
// shared constants and types of the clock output enable and loss monitor
// assumes a single 20 MHz system clock and a 32-bit AXI4-Lite register bus
package clock_output_enable_and_los_pkg;

   // system clock
   localparam int unsigned CLK_PERIOD_NS    = 50;

   // loss monitor timing
   localparam int unsigned LOS_TIMEOUT_NS   = 2000;
   localparam int unsigned LOS_TIMEOUT_CYC  = (LOS_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned LOS_DETECT_EDGES = 4;

   // structure
   localparam int unsigned NUM_OUT          = 8;
   localparam int unsigned NUM_IN           = 2;
   localparam int unsigned ADDR_W           = 8;

   // register byte offsets
   localparam logic [7:0] REG_OUT_EN        = 8'h00;
   localparam logic [7:0] REG_IN_CFG        = 8'h04;
   localparam logic [7:0] REG_LOSS_EVT      = 8'h08;
   localparam logic [7:0] REG_STATUS        = 8'h0c;

   // field positions
   localparam int unsigned IN_CFG_TERM0_POS = 0;
   localparam int unsigned IN_CFG_AC0_POS   = 1;
   localparam int unsigned IN_CFG_TERM1_POS = 2;
   localparam int unsigned IN_CFG_AC1_POS   = 3;
   localparam int unsigned LOSS_EVT_POS     = 0;
   localparam int unsigned STAT_LOSS_POS    = 0;
   localparam int unsigned STAT_SEL_POS     = 1;
   localparam int unsigned STAT_RUN_POS     = 8;

   // reset values
   localparam logic [NUM_OUT-1:0] OUT_EN_RST = 8'hff;
   localparam logic [3:0]         IN_CFG_RST = 4'h0;

   // bus responses
   localparam logic [1:0] RESP_OKAY         = 2'b00;
   localparam logic [1:0] RESP_SLVERR       = 2'b10;

   // per-input receiver configuration, in register bit order
   typedef struct packed {
      logic ac1;
      logic term1;
      logic ac0;
      logic term0;
   } in_cfg_t;

   // pins that pass the input synchroniser together
   typedef struct packed {
      logic [NUM_OUT-1:0] enable_pin_n;
      logic               input_select;
      logic [NUM_IN-1:0]  ref_clock_in;
   } pin_bundle_t;

endpackage

// ==== verilog/clock_gate_cell.sv ====
// one output gate: enable resync on the input clock and glitch-free gating
// assumes ref_level_i is the filtered, parked input clock level on mclk_i
`timescale 1ns/10ps
`default_nettype none

module clock_gate_cell
(
   input  wire logic mclk_i,
   input  wire logic nrst_i,
   input  wire logic ref_level_i,
   input  wire logic ref_rise_i,
   input  wire logic enable_i,
   output logic      active_o,
   output logic      clk_o
);

   logic sync1_r;
   logic sync1_nxt;
   logic sync2_r;
   logic sync2_nxt;
   logic active_r;
   logic active_nxt;
   logic out_r;
   logic out_nxt;

   // enable moves only on input clock edges, and gating only while low
   always_comb
   begin
      sync1_nxt  = sync1_r;
      sync2_nxt  = sync2_r;
      if (ref_rise_i)
      begin
         sync1_nxt = enable_i;
         sync2_nxt = sync1_r;
      end
      active_nxt = ref_level_i ? active_r : sync2_r;
      out_nxt    = ref_level_i & active_r;             // stopped means low
   end

   // state registers
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sync1_r  <= 1'b0;
         sync2_r  <= 1'b0;
         active_r <= 1'b0;
         out_r    <= 1'b0;
      end
      else
      begin
         sync1_r  <= sync1_nxt;
         sync2_r  <= sync2_nxt;
         active_r <= active_nxt;
         out_r    <= out_nxt;
      end
   end

   assign active_o = active_r;
   assign clk_o    = out_r;

endmodule

`default_nettype wire

// ==== verilog/clock_output_enable_and_los.sv ====
// output enable gating and loss monitor of a two-input reference clock mux
// assumes input clocks and pins are asynchronous and sampled on mclk_i;
// registers sit behind an AXI4-Lite slave
// Operation
// - watch the input clock continuously and flag loss when it is absent
// - on loss pull the open-drain loss pin low and set the event bit
// - loss pin is low from reset until a valid clock is detected
// - only the currently selected input clock is monitored
// - after loss the clock path is parked low
// - an output runs only while all three enable mechanisms say enabled
// - outputs start and stop synchronously with no short pulses
// - each output has a register enable bit that resets to one
// - writing zero stops the output low, writing one restarts it cleanly
// - enable changes are resynchronised by the input clock
// - enable pin low enables, high disables and stops outputs low
// - per-input bit switches on the ac-coupling self-bias network
// - per-input bit switches on the receiver pull-down termination
// - each of the two inputs has its own bias and termination bits
// - event bit stays set until software writes one to clear it
`timescale 1ns/10ps
`default_nettype none

module clock_output_enable_and_los
#(
   parameter int unsigned N_OUT = clock_output_enable_and_los_pkg::NUM_OUT
)
(
   input  wire logic                                           mclk_i,
   input  wire logic                                           nrst_i,
   // pins
   input  wire logic [clock_output_enable_and_los_pkg::NUM_IN-1:0] ref_clock_in_i,
   input  wire logic                                           input_select_i,
   input  wire logic [N_OUT-1:0]                               output_enable_pin_n_i,
   output logic [N_OUT-1:0]                                    clk_out_o,
   output logic                                                signal_loss_n_o,
   output logic                                                signal_loss_n_oe_o,
   output logic [clock_output_enable_and_los_pkg::NUM_IN-1:0]  ac_couple_bias_en_o,
   output logic [clock_output_enable_and_los_pkg::NUM_IN-1:0]  rx_term_en_o,
   // AXI4-Lite slave
   input  wire logic [clock_output_enable_and_los_pkg::ADDR_W-1:0] axi_awaddr_i,
   input  wire logic                                           axi_awvalid_i,
   output logic                                                axi_awready_o,
   input  wire logic [31:0]                                    axi_wdata_i,
   input  wire logic [3:0]                                     axi_wstrb_i,
   input  wire logic                                           axi_wvalid_i,
   output logic                                                axi_wready_o,
   output logic [1:0]                                          axi_bresp_o,
   output logic                                                axi_bvalid_o,
   input  wire logic                                           axi_bready_i,
   input  wire logic [clock_output_enable_and_los_pkg::ADDR_W-1:0] axi_araddr_i,
   input  wire logic                                           axi_arvalid_i,
   output logic                                                axi_arready_o,
   output logic [31:0]                                         axi_rdata_o,
   output logic [1:0]                                          axi_rresp_o,
   output logic                                                axi_rvalid_o,
   input  wire logic                                           axi_rready_i
);
   import clock_output_enable_and_los_pkg::*;

   localparam int unsigned PIN_W = $bits(pin_bundle_t);
   localparam int unsigned TMO_W = $clog2(LOS_TIMEOUT_CYC + 1);
   localparam int unsigned DET_W = $clog2(LOS_DETECT_EDGES + 1);
   localparam logic [TMO_W-1:0] TMO_MAX = TMO_W'(LOS_TIMEOUT_CYC);
   localparam logic [DET_W-1:0] DET_MAX = DET_W'(LOS_DETECT_EDGES);

   // the sideband shift interface is not part of this block: it always enables
   localparam logic [N_OUT-1:0] SIDEBAND_EN = {N_OUT{1'b1}};

   // ---------------- pin synchroniser ----------------
   pin_bundle_t pin_raw;
   logic [PIN_W-1:0] s1_r;
   logic [PIN_W-1:0] s2_r;
   logic [PIN_W-1:0] s3_r;
   logic [PIN_W-1:0] filt_r;
   logic [PIN_W-1:0] filt_nxt;
   pin_bundle_t pin_f;

   assign pin_raw.enable_pin_n = output_enable_pin_n_i;
   assign pin_raw.input_select = input_select_i;
   assign pin_raw.ref_clock_in = ref_clock_in_i;
   assign pin_f                = pin_bundle_t'(filt_r);

   // a pin change counts once the second and third stage agree
   always_comb
   begin
      for (int k = 0; k < PIN_W; k++)
      begin
         filt_nxt[k] = (s2_r[k] == s3_r[k]) ? s3_r[k] : filt_r[k];
      end
   end

   // synchroniser registers; first stage feeds only the second
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s1_r   <= '0;
         s2_r   <= '0;
         s3_r   <= '0;
         filt_r <= '0;
      end
      else
      begin
         s1_r   <= pin_raw;
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         filt_r <= filt_nxt;
      end
   end

   // ---------------- loss monitor ----------------
   logic             sel_level;
   logic             sel_prev_r;
   logic             sel_prev_nxt;
   logic             sel_rise;
   logic [TMO_W-1:0] tmo_r;
   logic [TMO_W-1:0] tmo_nxt;
   logic [DET_W-1:0] det_r;
   logic [DET_W-1:0] det_nxt;
   logic             loss_r;
   logic             loss_nxt;
   logic             loss_set;

   assign sel_level = pin_f.input_select ? pin_f.ref_clock_in[1]
                                         : pin_f.ref_clock_in[0];
   assign sel_rise  = sel_level & ~sel_prev_r;

   // edge watchdog: no rising edge for the timeout declares loss
   always_comb
   begin
      sel_prev_nxt = sel_level;
      tmo_nxt      = tmo_r;
      det_nxt      = det_r;
      loss_nxt     = loss_r;
      if (sel_rise)
      begin
         tmo_nxt = '0;
         if (loss_r)
         begin
            if (det_r == DET_MAX - 1'b1)
            begin
               det_nxt  = '0;
               loss_nxt = 1'b0;   // release only after a run of edges
            end
            else
            begin
               det_nxt = det_r + 1'b1;
            end
         end
      end
      else if (tmo_r == TMO_MAX - 1'b1)
      begin
         tmo_nxt  = '0;
         det_nxt  = '0;
         loss_nxt = 1'b1;
      end
      else
      begin
         tmo_nxt = tmo_r + 1'b1;
      end
   end

   assign loss_set = loss_nxt & ~loss_r;

   // monitor registers; loss is asserted from reset
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sel_prev_r <= 1'b0;
         tmo_r      <= '0;
         det_r      <= '0;
         loss_r     <= 1'b1;
      end
      else
      begin
         sel_prev_r <= sel_prev_nxt;
         tmo_r      <= tmo_nxt;
         det_r      <= det_nxt;
         loss_r     <= loss_nxt;
      end
   end

   // ---------------- parked clock path and output gates ----------------
   logic             park_level;
   logic             park_prev_r;
   logic             park_rise;
   logic [N_OUT-1:0] run_en;
   logic [N_OUT-1:0] active;

   // parked on the declaring cycle, so a clock stuck high cannot leak one more cycle
   assign park_level = sel_level & ~loss_nxt;
   assign park_rise  = park_level & ~park_prev_r;

   // edge history of the parked clock
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         park_prev_r <= 1'b0;
      end
      else
      begin
         park_prev_r <= park_level;
      end
   end

   logic [N_OUT-1:0] out_en_r;
   logic [N_OUT-1:0] out_en_nxt;

   // one gate cell per output
   genvar gi;
   generate
      for (gi = 0; gi < N_OUT; gi++)
      begin : g_out
         assign run_en[gi] = out_en_r[gi] & ~pin_f.enable_pin_n[gi]
                           & SIDEBAND_EN[gi];
         clock_gate_cell u_gate
         (
            .mclk_i      (mclk_i),
            .nrst_i      (nrst_i),
            .ref_level_i (park_level),
            .ref_rise_i  (park_rise),
            .enable_i    (run_en[gi]),
            .active_o    (active[gi]),
            .clk_o       (clk_out_o[gi])
         );
      end
   endgenerate

   // ---------------- AXI4-Lite slave ----------------
   logic              aw_have_r, aw_have_nxt;
   logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
   logic              w_have_r, w_have_nxt;
   logic [31:0]       wdata_r, wdata_nxt;
   logic              wstrb0_r, wstrb0_nxt;
   logic              awready_r, awready_nxt;
   logic              wready_r, wready_nxt;
   logic              bvalid_r, bvalid_nxt;
   logic [1:0]        bresp_r, bresp_nxt;
   logic              arready_r, arready_nxt;
   logic              rvalid_r, rvalid_nxt;
   logic [1:0]        rresp_r, rresp_nxt;
   logic [31:0]       rdata_r, rdata_nxt;
   logic              wr_fire;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0]       wr_data;
   logic              wr_lane0;
   in_cfg_t           in_cfg_r, in_cfg_nxt;
   logic              evt_r, evt_nxt;

   // channel handshakes; address and data taken in either order
   always_comb
   begin
      aw_have_nxt = aw_have_r;
      awaddr_nxt  = awaddr_r;
      w_have_nxt  = w_have_r;
      wdata_nxt   = wdata_r;
      wstrb0_nxt  = wstrb0_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      rvalid_nxt  = rvalid_r;
      rresp_nxt   = rresp_r;
      rdata_nxt   = rdata_r;
      wr_fire     = 1'b0;
      if (axi_awvalid_i && awready_r)
      begin
         aw_have_nxt = 1'b1;
         awaddr_nxt  = axi_awaddr_i;
      end
      if (axi_wvalid_i && wready_r)
      begin
         w_have_nxt = 1'b1;
         wdata_nxt  = axi_wdata_i;
         wstrb0_nxt = axi_wstrb_i[0];
      end
      wr_addr  = awaddr_nxt;
      wr_data  = wdata_nxt;
      wr_lane0 = wstrb0_nxt;
      if (bvalid_r && axi_bready_i)
      begin
         bvalid_nxt = 1'b0;
      end
      if (!bvalid_r && aw_have_nxt && w_have_nxt)
      begin
         wr_fire     = 1'b1;
         aw_have_nxt = 1'b0;
         w_have_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = (wr_addr > REG_STATUS || wr_addr[1:0] != 2'b00) ? RESP_SLVERR
                                                                       : RESP_OKAY;
      end
      if (rvalid_r && axi_rready_i)
      begin
         rvalid_nxt = 1'b0;
      end
      if (axi_arvalid_i && arready_r)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = RESP_OKAY;
         rdata_nxt  = '0;
         case (axi_araddr_i)
            REG_OUT_EN:   rdata_nxt[N_OUT-1:0] = out_en_r;
            REG_IN_CFG:   rdata_nxt[3:0] = in_cfg_r;
            REG_LOSS_EVT: rdata_nxt[LOSS_EVT_POS] = evt_r;
            REG_STATUS:
            begin
               rdata_nxt[STAT_LOSS_POS]                    = loss_r;
               rdata_nxt[STAT_SEL_POS]                     = pin_f.input_select;
               rdata_nxt[STAT_RUN_POS +: N_OUT]            = active;
            end
            default:      rresp_nxt = RESP_SLVERR;
         endcase
      end
      awready_nxt = ~aw_have_nxt & ~bvalid_nxt;
      wready_nxt  = ~w_have_nxt & ~bvalid_nxt;
      arready_nxt = ~rvalid_nxt;
   end

   // bus registers
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         aw_have_r <= 1'b0;
         awaddr_r  <= '0;
         w_have_r  <= 1'b0;
         wdata_r   <= '0;
         wstrb0_r  <= 1'b0;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rresp_r   <= RESP_OKAY;
         rdata_r   <= '0;
      end
      else
      begin
         aw_have_r <= aw_have_nxt;
         awaddr_r  <= awaddr_nxt;
         w_have_r  <= w_have_nxt;
         wdata_r   <= wdata_nxt;
         wstrb0_r  <= wstrb0_nxt;
         awready_r <= awready_nxt;
         wready_r  <= wready_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r  <= rvalid_nxt;
         rresp_r   <= rresp_nxt;
         rdata_r   <= rdata_nxt;
      end
   end

   // ---------------- control registers ----------------
   // register writes; a new loss wins over a clearing write
   always_comb
   begin
      out_en_nxt = out_en_r;
      in_cfg_nxt = in_cfg_r;
      evt_nxt    = evt_r;
      if (wr_fire && wr_lane0)
      begin
         case (wr_addr)
            REG_OUT_EN:   out_en_nxt = wr_data[N_OUT-1:0];
            REG_IN_CFG:   in_cfg_nxt = in_cfg_t'(wr_data[3:0]);
            REG_LOSS_EVT:
            begin
               if (wr_data[LOSS_EVT_POS])
               begin
                  evt_nxt = 1'b0;   // writing zero leaves it
               end
            end
            default:      evt_nxt = evt_r;
         endcase
      end
      if (loss_set)
      begin
         evt_nxt = 1'b1;
      end
   end

   // control registers and the open-drain pin driver
   logic lo_r;
   logic loss_oe_r;
   logic [NUM_IN-1:0] ac_r;
   logic [NUM_IN-1:0] term_r;
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         out_en_r  <= OUT_EN_RST;
         in_cfg_r  <= IN_CFG_RST;
         evt_r     <= 1'b0;
         lo_r      <= 1'b0;
         loss_oe_r <= 1'b1;
         ac_r      <= '0;
         term_r    <= '0;
      end
      else
      begin
         out_en_r  <= out_en_nxt;
         in_cfg_r  <= in_cfg_nxt;
         evt_r     <= evt_nxt;
         lo_r      <= 1'b0;
         loss_oe_r <= loss_nxt;
         ac_r      <= {in_cfg_nxt.ac1, in_cfg_nxt.ac0};
         term_r    <= {in_cfg_nxt.term1, in_cfg_nxt.term0};
      end
   end

   assign signal_loss_n_o     = lo_r;
   assign signal_loss_n_oe_o  = loss_oe_r;
   assign ac_couple_bias_en_o = ac_r;
   assign rx_term_en_o        = term_r;
   assign axi_awready_o       = awready_r;
   assign axi_wready_o        = wready_r;
   assign axi_bvalid_o        = bvalid_r;
   assign axi_bresp_o         = bresp_r;
   assign axi_arready_o       = arready_r;
   assign axi_rvalid_o        = rvalid_r;
   assign axi_rresp_o         = rresp_r;
   assign axi_rdata_o         = rdata_r;

endmodule

`default_nettype wire

// ==== tb/clock_output_enable_and_los_assertions.sv ====
// concurrent checks on the ports of the clock output enable and loss block
// assumes a running input clock has a half period of a few mclk_i cycles
`timescale 1ns/10ps
`default_nettype none

module clock_output_enable_and_los_assertions
#(
   parameter int unsigned N_OUT = 8
)
(
   input wire logic             mclk_i,
   input wire logic             nrst_i,
   input wire logic [1:0]       ref_clock_in_i,
   input wire logic             input_select_i,
   input wire logic [N_OUT-1:0] output_enable_pin_n_i,
   input wire logic [N_OUT-1:0] clk_out_o,
   input wire logic             signal_loss_n_oe_o,
   input wire logic [1:0]       ac_couple_bias_en_o,
   input wire logic [1:0]       rx_term_en_o,
   input wire logic             axi_wvalid_i,
   input wire logic             axi_wready_o,
   input wire logic [1:0]       axi_bresp_o,
   input wire logic             axi_bvalid_o,
   input wire logic             axi_bready_i,
   input wire logic             axi_arvalid_i,
   input wire logic             axi_arready_o,
   input wire logic [31:0]      axi_rdata_o,
   input wire logic             axi_rvalid_o,
   input wire logic             axi_rready_i
);
   logic [7:0] stall_r, stall_nxt, pin_hi_r, pin_hi_nxt;
   logic       lvl_r, sel_r;

   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);

   // cycles the selected input level has stood still and the first enable pin has stood high
   always_comb
   begin
      stall_nxt  = (ref_clock_in_i[input_select_i] != lvl_r || input_select_i != sel_r) ?
                   8'h00 : stall_r + {7'h0, stall_r != 8'hff};
      pin_hi_nxt = output_enable_pin_n_i[0] ? pin_hi_r + {7'h0, pin_hi_r != 8'hff} : 8'h00;
   end

   // register the helper counters
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         stall_r  <= 8'h00;
         pin_hi_r <= 8'h00;
         lvl_r    <= 1'b0;
         sel_r    <= 1'b0;
      end
      else
      begin
         stall_r  <= stall_nxt;
         pin_hi_r <= pin_hi_nxt;
         lvl_r    <= ref_clock_in_i[input_select_i];
         sel_r    <= input_select_i;
      end
   end

   a_loss_timeout: assert property (stall_r >= 8'h38 |-> signal_loss_n_oe_o)
      else $error("loss not flagged on a stalled selected clock");
   a_loss_recover: assert property ($fell(signal_loss_n_oe_o) |-> stall_r < 8'h10)
      else $error("loss released without a running clock");
   a_parked_low: assert property (signal_loss_n_oe_o |-> clk_out_o == '0)
      else $error("outputs not parked low during loss");
   a_pin_stop: assert property (pin_hi_r >= 8'h40 |-> !clk_out_o[0])
      else $error("output runs with its enable pin high");
   a_whole_pulse: assert property ($rose(clk_out_o[0]) |=>
      (clk_out_o[0] || signal_loss_n_oe_o) [*2])
      else $error("truncated output pulse");
   a_cfg_on_write: assert property (!$stable({ac_couple_bias_en_o, rx_term_en_o}) |->
      axi_bvalid_o || $past(axi_bvalid_o) || $past(axi_wvalid_i && axi_wready_o))
      else $error("input config changed without a write");
   a_bresp_hold: assert property (axi_bvalid_o && !axi_bready_i |=>
      axi_bvalid_o && $stable(axi_bresp_o))
      else $error("write response dropped early");
   a_rdata_hold: assert property (axi_rvalid_o && !axi_rready_i |=>
      axi_rvalid_o && $stable(axi_rdata_o))
      else $error("read data dropped early");
   a_read_answer: assert property (axi_arvalid_i && axi_arready_o |=> axi_rvalid_o)
      else $error("read answer late");

   c_lost: cover property ($rose(signal_loss_n_oe_o));
   c_recover: cover property ($fell(signal_loss_n_oe_o));
   c_run: cover property ($rose(clk_out_o[0]));
endmodule

bind clock_output_enable_and_los clock_output_enable_and_los_assertions #(.N_OUT(N_OUT)) chk_i
(
   .mclk_i, .nrst_i, .ref_clock_in_i, .input_select_i, .output_enable_pin_n_i, .clk_out_o,
   .signal_loss_n_oe_o, .ac_couple_bias_en_o, .rx_term_en_o, .axi_wvalid_i, .axi_wready_o,
   .axi_bresp_o, .axi_bvalid_o, .axi_bready_i, .axi_arvalid_i, .axi_arready_o, .axi_rdata_o,
   .axi_rvalid_o, .axi_rready_i
);
`default_nettype wire

// ==== tb/ref_clock_source.sv ====
// two input reference clocks facing the block's clock pins
// assumes half periods are counted on falling mclk_i edges
`timescale 1ns/10ps
`default_nettype none

module ref_clock_source
#(
   parameter int unsigned HALF = 4
)
(
   input  wire logic       mclk_i,
   input  wire logic [1:0] run_i,
   output logic      [1:0] ref_o
);
   int unsigned cnt = 0;

   initial ref_o = 2'b00;

   // a running input toggles every HALF cycles, a stopped one stands low
   always @(negedge mclk_i)
   begin
      cnt = (cnt + 1) % HALF;
      for (int k = 0; k < 2; k++)
         ref_o[k] <= run_i[k] ? ref_o[k] ^ (cnt == 0) : 1'b0;
   end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench of the clock output enable and loss block
// assumes the clock source model and the assertion checker alongside
`timescale 1ns/10ps
`default_nettype none

module testbench;
   import clock_output_enable_and_los_pkg::*;
   logic        mclk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        sel    = 1'b0;
   logic [1:0]  run    = 2'b00;
   logic [7:0]  pin_n  = 8'h00;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata  = 32'h0;
   logic [3:0]  wstrb  = 4'hf;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, loss_d, loss_oe;
   logic [1:0]  ref_clk, bias, term, bresp, rresp, rsp;
   logic [7:0]  clk_out, en, seen;
   logic [31:0] rdata, rd;
   logic [31:0] lfsr = 32'hdde2;
   in_cfg_t     c;
   int          fails = 0, n_tests = 0, cycles = 0;

   ref_clock_source #(.HALF(4)) ref_src (.mclk_i(mclk_i), .run_i(run), .ref_o(ref_clk));

   clock_output_enable_and_los #(.N_OUT(8)) uut
   (
      .mclk_i(mclk_i), .nrst_i(nrst_i), .ref_clock_in_i(ref_clk), .input_select_i(sel),
      .output_enable_pin_n_i(pin_n), .clk_out_o(clk_out), .signal_loss_n_o(loss_d),
      .signal_loss_n_oe_o(loss_oe), .ac_couple_bias_en_o(bias), .rx_term_en_o(term),
      .axi_awaddr_i(awaddr), .axi_awvalid_i(awvalid), .axi_awready_o(awready),
      .axi_wdata_i(wdata), .axi_wstrb_i(wstrb), .axi_wvalid_i(wvalid), .axi_wready_o(wready),
      .axi_bresp_o(bresp), .axi_bvalid_o(bvalid), .axi_bready_i(bready),
      .axi_araddr_i(araddr), .axi_arvalid_i(arvalid), .axi_arready_o(arready),
      .axi_rdata_o(rdata), .axi_rresp_o(rresp), .axi_rvalid_o(rvalid), .axi_rready_i(rready)
   );

   // clock and hang guard
   always #25 mclk_i = ~mclk_i;
   always @(posedge mclk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         end_sim();
      end
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // outputs that should run: register bit set and pin low
   function automatic logic [7:0] exp_run(input logic [7:0] e, input logic [7:0] p);
      return e & ~p;
   endfunction

   task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
      n_tests++;
      if (seen_v !== exp_v)
      begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen_v, exp_v);
      end
   endtask

   // one write: address and data offered together, each released when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic b_ok;
      b_ok = 1'b0;
      @(posedge mclk_i);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!b_ok)
      begin
         @(posedge mclk_i);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) b_ok = 1'b1;
      end
      bready <= 1'b0;
      rsp = bresp;
   endtask

   // one read: data and response taken at the handshake edge
   task automatic axi_rd(input logic [7:0] a);
      logic r_ok;
      r_ok = 1'b0;
      @(posedge mclk_i);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!r_ok)
      begin
         @(posedge mclk_i);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) r_ok = 1'b1;
      end
      rready <= 1'b0;
      rd  = rdata;
      rsp = rresp;
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // main sequence
   initial
   begin
      repeat (5) @(posedge mclk_i);
      nrst_i <= 1'b1;
      @(posedge mclk_i);
      chk(loss_oe, 1'b1);
      axi_rd(REG_OUT_EN);
      chk(rd, 32'h000000ff);
      axi_rd(REG_IN_CFG);
      chk(rd, 32'h0);
      axi_rd(8'h10);
      chk(rsp, RESP_SLVERR);
      axi_wr(8'h10, 32'h0);
      chk(rsp, RESP_SLVERR);
      run <= 2'b01;
      repeat (60) @(posedge mclk_i);
      chk(loss_oe, 1'b0);
      // corners first: all stopped, all restarted, then random mixes
      for (int i = 0; i < 6; i++)
      begin
         lfsr = lfsr_next(lfsr);
         c    = lfsr[3:0];
         en   = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : lfsr[15:8];
         axi_wr(REG_IN_CFG, {28'h0, c});
         axi_wr(REG_OUT_EN, {24'h0, en});
         pin_n <= (i < 2) ? 8'h00 : lfsr[23:16];
         repeat (60) @(posedge mclk_i);
         chk(bias, {c.ac1, c.ac0});
         chk(term, {c.term1, c.term0});
         seen = 8'h00;
         repeat (16)
         begin
            @(posedge mclk_i);
            seen = seen | clk_out;
         end
         chk(seen, exp_run(en, pin_n));
         axi_rd(REG_STATUS);
         chk(rd[15:8], exp_run(en, pin_n));
      end
      run <= 2'b10;
      repeat (60) @(posedge mclk_i);
      chk(loss_oe, 1'b1);
      chk(loss_d, 1'b0);
      chk(clk_out, 8'h00);
      // an enable write while the input is stopped must not move the gates
      axi_wr(REG_OUT_EN, 32'h0);
      chk(rsp, RESP_OKAY);
      axi_rd(REG_STATUS);
      chk(rd[15:8], exp_run(en, pin_n));
      axi_rd(REG_LOSS_EVT);
      chk(rd, 32'h1);
      sel <= 1'b1;
      repeat (60) @(posedge mclk_i);
      chk(loss_oe, 1'b0);
      axi_rd(REG_STATUS);
      chk(rd[1], 1'b1);
      axi_wr(REG_LOSS_EVT, 32'h0);
      axi_rd(REG_LOSS_EVT);
      chk(rd, 32'h1);
      axi_wr(REG_LOSS_EVT, 32'h1);
      axi_rd(REG_LOSS_EVT);
      chk(rd, 32'h0);
      run <= 2'b01;
      repeat (60) @(posedge mclk_i);
      chk(loss_oe, 1'b1);
      end_sim();
   end
endmodule
`default_nettype wire
